// ==== rtl/sphs_pkg.sv ====
// constants and carrier types for the solenoid peak/hold status controller
package sphs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned SPHS_CLK_HZ = 100_000_000;
  localparam int unsigned SPHS_CLK_PER_MS = SPHS_CLK_HZ / 1000;
  localparam int unsigned SPHS_BLANK_NS = 3000;
  // least time: round up
  localparam int unsigned SPHS_BLANK_CYCLES = (SPHS_BLANK_NS * (SPHS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SPHS_PEAK_TIME_MS = 50;
  localparam int unsigned SPHS_PEAK_CYCLES = SPHS_PEAK_TIME_MS * SPHS_CLK_PER_MS;
  localparam int unsigned SPHS_STARTUP_MS = 2;
  localparam int unsigned SPHS_STARTUP_CYCLES = SPHS_STARTUP_MS * SPHS_CLK_PER_MS;
  localparam int unsigned SPHS_PWM_PERIOD_US = 40;
  localparam int unsigned SPHS_PWM_PERIOD_CYCLES = SPHS_PWM_PERIOD_US * (SPHS_CLK_HZ / 1_000_000);
  localparam int unsigned SPHS_SLOW_OSC_HZ = 2048;
  localparam int unsigned SPHS_SLOW_DIV = SPHS_CLK_HZ / SPHS_SLOW_OSC_HZ;
  localparam int unsigned SPHS_SLOW_PRESCALE = 64;
  localparam int unsigned SPHS_BLINK_HZ = 1;
  // delay line with inverted feedback: period is twice its length in ticks
  localparam int unsigned SPHS_BLINK_STAGES =
    (SPHS_SLOW_OSC_HZ / SPHS_SLOW_PRESCALE) / (2 * SPHS_BLINK_HZ);

  // ---------------------------------------------------------------
  // widths and reference table
  // ---------------------------------------------------------------
  localparam int unsigned SPHS_NUM_SOL = 2;
  localparam int unsigned SPHS_REF_W = 8;
  localparam int unsigned SPHS_TBL_DEPTH = 16;
  localparam int unsigned SPHS_IDX_W = 4;
  localparam int unsigned SPHS_PER_W = 12;
  localparam int unsigned SPHS_PRE_W = 6;
  // codes 218 and 196 give 864 mV and 160 mV for the first solenoid
  localparam logic [SPHS_REF_W-1:0] SPHS_REF_INIT [0:SPHS_TBL_DEPTH-1] = '{
    8'hFE, 8'hC3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hDA, 8'hC4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // peak entry per solenoid; the hold entry is the next one
  localparam logic [SPHS_IDX_W-1:0] SPHS_PEAK_IDX [0:SPHS_NUM_SOL-1] = '{4'h8, 4'h0};
  localparam logic [SPHS_IDX_W-1:0] SPHS_IDX_STEP = 4'h1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SPHS_ST_IDLE  = 4'h1,
    SPHS_ST_BLANK = 4'h2,
    SPHS_ST_ON    = 4'h4,
    SPHS_ST_OFF   = 4'h8
  } sphs_state_t;

  typedef struct packed {
    logic drive;
    logic driver_on;
    logic ref_hold;
    logic [SPHS_REF_W-1:0] ref_code;
    logic green_led;
    logic red_led;
    logic fault_pin_o;
    logic fault_pin_oe_n;
  } sphs_sol_out_t;

  typedef struct packed {
    logic wr_en;
    logic [SPHS_IDX_W-1:0] addr;
    logic [SPHS_REF_W-1:0] data;
  } sphs_tbl_wr_t;

endpackage : sphs_pkg

// ==== rtl/sphs_ctrl.sv ====
// solenoid peak/hold controller: chopped drive, reference switch, status and fault pins
// What this block does
// [R01] 1 Hz indicator square wave is divided from the slow oscillator by a delay line.
// [R02] each driver fault flag is registered before reaching its pin.
// [R03] fault pins are open-drain; status indicator outputs are push-pull.
// [R04] green off while the command is low, steadily on while active without fault.
// [R05] green blinks at 1 Hz while the command is high and the solenoid reports a fault.
// [R06] red indicator is on exactly while a fault is present.
// [R07] peak regulation lasts 50 ms, then a pulse switches to the hold reference.
// [R08] reference codes of the first solenoid select 864 mV for peak and 160 mV for hold.
// [R09] drive stays high for 3 us blanking, then only until the comparator trips.
// [R10] comparator already tripped at blanking end gives the minimum on-time.
// [R11] reference table stays writable by the external controller through its port.
// [R12] peak-time pulse advances the reference selector from peak to hold entry.
// [R13] command low switches the generator and driver off at once.
// [R14] after a trip the drive stays low until the next period starts.
`timescale 1ns/1ps
module sphs_ctrl
  import sphs_pkg::*;
#(
  parameter int unsigned PEAK_CYCLES = SPHS_PEAK_CYCLES,
  parameter int unsigned STARTUP_CYCLES = SPHS_STARTUP_CYCLES,
  parameter int unsigned SLOW_DIV = SPHS_SLOW_DIV
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // solenoid commands, comparator trips and driver faults
  input wire logic [SPHS_NUM_SOL-1:0] sol_cmd,
  input wire logic [SPHS_NUM_SOL-1:0] current_trip,
  input wire logic [SPHS_NUM_SOL-1:0] drv_fault,
  // reference table write port from the serial register block
  input wire sphs_tbl_wr_t tbl_wr,
  // per-solenoid outputs and the ready flag
  output sphs_sol_out_t [SPHS_NUM_SOL-1:0] sol_out,
  output logic ready
);

  localparam int unsigned PK_W = $clog2(PEAK_CYCLES + 1);
  localparam int unsigned SU_W = $clog2(STARTUP_CYCLES + 1);
  localparam int unsigned SD_W = $clog2(SLOW_DIV + 1);
  localparam logic [PK_W-1:0] PK_LAST = PK_W'(PEAK_CYCLES - 1);
  localparam logic [SU_W-1:0] SU_LAST = SU_W'(STARTUP_CYCLES - 1);
  localparam logic [SD_W-1:0] SD_LAST = SD_W'(SLOW_DIV - 1);
  localparam logic [SPHS_PER_W-1:0] PER_LAST = SPHS_PER_W'(SPHS_PWM_PERIOD_CYCLES - 1);
  localparam logic [SPHS_PER_W-1:0] BLANK_LAST = SPHS_PER_W'(SPHS_BLANK_CYCLES - 1);
  localparam logic [SPHS_PRE_W-1:0] PRE_LAST = SPHS_PRE_W'(SPHS_SLOW_PRESCALE - 1);

  // ---------------------------------------------------------------
  // start-up delay after reset
  // ---------------------------------------------------------------
  logic [SU_W-1:0] su_cnt_ff;
  logic ready_ff;

  // drive and driver-on outputs stay quiet until supplies and the charge pump have settled
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      su_cnt_ff <= '0;
      ready_ff <= 1'b0;
    end
    else if (!ready_ff)
    begin
      su_cnt_ff <= su_cnt_ff + 1'b1;
      ready_ff <= (su_cnt_ff == SU_LAST);
    end
  end

  assign ready = ready_ff;

  // ---------------------------------------------------------------
  // slow oscillator and 1 Hz blink
  // ---------------------------------------------------------------
  logic [SD_W-1:0] slow_cnt_ff;
  logic slow_tick_ff;
  logic [SPHS_PRE_W-1:0] pre_cnt_ff;
  logic [SPHS_BLINK_STAGES-1:0] blink_line_ff;
  logic blink_step;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_cnt_ff <= '0;
      slow_tick_ff <= 1'b0;
    end
    else
    begin
      slow_cnt_ff <= (slow_cnt_ff == SD_LAST) ? '0 : slow_cnt_ff + 1'b1;
      slow_tick_ff <= (slow_cnt_ff == SD_LAST);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_ff <= '0;
    else if (slow_tick_ff)
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
  end

  assign blink_step = slow_tick_ff && (pre_cnt_ff == PRE_LAST);

  // inverted-feedback delay line: the last tap toggles every length of ticks
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      blink_line_ff <= '0;
    else if (blink_step)
      blink_line_ff <= {blink_line_ff[SPHS_BLINK_STAGES-2:0],
                        ~blink_line_ff[SPHS_BLINK_STAGES-1]}; // see [R01]
  end

  // ---------------------------------------------------------------
  // reference table
  // ---------------------------------------------------------------
  logic [SPHS_REF_W-1:0] tbl_ff [0:SPHS_TBL_DEPTH-1];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < SPHS_TBL_DEPTH; k++)
        tbl_ff[k] <= SPHS_REF_INIT[k];
    end
    else if (tbl_wr.wr_en)
      tbl_ff[tbl_wr.addr] <= tbl_wr.data; // see [R11]
  end

  // ---------------------------------------------------------------
  // per-solenoid channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < SPHS_NUM_SOL; i++)
  begin : g_sol
    sphs_state_t state_ff;
    sphs_state_t nxt_state;
    logic [SPHS_PER_W-1:0] per_cnt_ff;
    logic [PK_W-1:0] pk_cnt_ff;
    logic pk_pulse_ff;
    logic hold_ff;
    logic drive_ff;
    logic on_ff;
    logic [SPHS_REF_W-1:0] ref_ff;
    logic fault_ff;
    logic green_ff;
    logic red_ff;
    logic oe_n_ff;
    logic pin_o_ff;
    logic active;
    logic per_end;

    assign active = sol_cmd[i] && ready_ff;
    assign per_end = (per_cnt_ff == PER_LAST);

    always_comb
    begin
      nxt_state = state_ff;
      if (!active)
        nxt_state = SPHS_ST_IDLE; // see [R13]
      else
      begin
        case (state_ff)
          SPHS_ST_IDLE: nxt_state = SPHS_ST_BLANK;
          SPHS_ST_BLANK:
          begin
            if (per_cnt_ff == BLANK_LAST)
              nxt_state = current_trip[i] ? SPHS_ST_OFF : SPHS_ST_ON; // see [R09] [R10]
          end
          SPHS_ST_ON:
          begin
            if (per_end)
              nxt_state = SPHS_ST_BLANK;
            else if (current_trip[i])
              nxt_state = SPHS_ST_OFF; // see [R09]
          end
          SPHS_ST_OFF:
          begin
            if (per_end)
              nxt_state = SPHS_ST_BLANK; // see [R14]
          end
          default: nxt_state = SPHS_ST_IDLE;
        endcase
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        state_ff <= SPHS_ST_IDLE;
      else
        state_ff <= nxt_state;
    end

    // period counter restarts on every activation
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        per_cnt_ff <= '0;
      else if (state_ff == SPHS_ST_IDLE || nxt_state == SPHS_ST_IDLE || per_end)
        per_cnt_ff <= '0;
      else
        per_cnt_ff <= per_cnt_ff + 1'b1;
    end

    // drive follows the next state so a release or trip costs no extra cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        drive_ff <= 1'b0;
        on_ff <= 1'b0;
      end
      else
      begin
        drive_ff <= (nxt_state == SPHS_ST_BLANK) || (nxt_state == SPHS_ST_ON); // see [R09] [R14]
        on_ff <= active; // see [R13]
      end
    end

    // peak-time delay: one pulse after the peak interval
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pk_cnt_ff <= '0;
        pk_pulse_ff <= 1'b0;
      end
      else if (!active)
      begin
        pk_cnt_ff <= '0;
        pk_pulse_ff <= 1'b0;
      end
      else
      begin
        if (pk_cnt_ff != PK_LAST)
          pk_cnt_ff <= pk_cnt_ff + 1'b1;
        pk_pulse_ff <= (pk_cnt_ff == PK_LAST) && !hold_ff && !pk_pulse_ff; // see [R07]
      end
    end

    // reference selector advances one entry on the pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        hold_ff <= 1'b0;
      else if (!active)
        hold_ff <= 1'b0;
      else if (pk_pulse_ff)
        hold_ff <= 1'b1; // see [R12]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        ref_ff <= '0;
      else
        ref_ff <= tbl_ff[hold_ff ? SPHS_PEAK_IDX[i] + SPHS_IDX_STEP : SPHS_PEAK_IDX[i]]; // see [R08]
    end

    // fault path: registered so a glitch on the flag never reaches a pin
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        fault_ff <= 1'b0;
        oe_n_ff <= 1'b1;
        pin_o_ff <= 1'b0;
      end
      else
      begin
        fault_ff <= drv_fault[i]; // see [R02]
        oe_n_ff <= ~drv_fault[i]; // see [R02] [R03]
        pin_o_ff <= 1'b0; // see [R03]
      end
    end

    // indicators, push-pull
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        green_ff <= 1'b0;
        red_ff <= 1'b0;
      end
      else
      begin
        green_ff <= sol_cmd[i] && (!fault_ff || blink_line_ff[SPHS_BLINK_STAGES-1]); // see [R04] [R05]
        red_ff <= fault_ff; // see [R06]
      end
    end

    assign sol_out[i] = '{drive: drive_ff, driver_on: on_ff, ref_hold: hold_ff,
                          ref_code: ref_ff, green_led: green_ff, red_led: red_ff,
                          fault_pin_o: pin_o_ff, fault_pin_oe_n: oe_n_ff};
  end

endmodule : sphs_ctrl

// ==== bench/sphs_ctrl_props.sv ====
// port assertions for the solenoid peak/hold controller
`timescale 1ns/1ps
module sphs_ctrl_chk
  import sphs_pkg::*;
#(
  parameter int unsigned PEAK_CYCLES = 200,
  parameter int unsigned STARTUP_CYCLES = 20,
  parameter int unsigned SLOW_DIV = 2
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // inputs of the design
  input wire logic [SPHS_NUM_SOL-1:0] sol_cmd,
  input wire logic [SPHS_NUM_SOL-1:0] current_trip,
  input wire logic [SPHS_NUM_SOL-1:0] drv_fault,
  input wire sphs_tbl_wr_t tbl_wr,
  // outputs of the design
  input wire sphs_sol_out_t [SPHS_NUM_SOL-1:0] sol_out,
  input wire logic ready
);
  wire sphs_sol_out_t o0 = sol_out[0];
  wire sphs_sol_out_t o1 = sol_out[1];
  int on_cnt_ff;
  int act_cnt_ff;
  logic [SPHS_REF_W-1:0] hold_ff;
  // ---
  // helpers: on-time and activation counters, shadow of the hold byte
  // ---
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_cnt_ff <= 0;
      act_cnt_ff <= 0;
    end
    else
    begin
      on_cnt_ff <= o0.drive ? on_cnt_ff + 1 : 0;
      act_cnt_ff <= o0.driver_on ? act_cnt_ff + 1 : 0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_ff <= SPHS_REF_INIT[9];
    else if (tbl_wr.wr_en && tbl_wr.addr == 4'h9)
      hold_ff <= tbl_wr.data;
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  property p_fault_reg; $rose(drv_fault[1]) |=> !o1.fault_pin_oe_n ##1 o1.red_led; endproperty
  a_fault_reg: assert property (p_fault_reg) else $error("fault pin late");
  property p_od; o0.fault_pin_o == 1'b0 && o1.fault_pin_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("fault pin driven high");
  property p_green_off; !sol_cmd[0] |=> !o0.green_led; endproperty
  a_green_off: assert property (p_green_off) else $error("green lit while idle");
  property p_green_on; sol_cmd[1] && !$past(drv_fault[1]) |=> o1.green_led; endproperty
  a_green_on: assert property (p_green_on) else $error("green dark while active");
  property p_red; o1.red_led == $past(drv_fault[1], 2); endproperty
  a_red: assert property (p_red) else $error("red indicator wrong");
  property p_blank; o0.drive && on_cnt_ff < 299 && sol_cmd[0] |=> o0.drive; endproperty
  a_blank: assert property (p_blank) else $error("blanking cut short");
  property p_min_on; o0.drive && on_cnt_ff == 299 && current_trip[0] |=> !o0.drive; endproperty
  a_min_on: assert property (p_min_on) else $error("minimum on-time wrong");
  property p_cmd_off; !sol_cmd[0] |=> !o0.drive && !o0.driver_on; endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("drive not off");
  property p_rest_low; $fell(o0.drive) && sol_cmd[0] && on_cnt_ff < 3000 |-> !o0.drive[*8];
  endproperty
  a_rest_low: assert property (p_rest_low) else $error("drive re-armed early");
  property p_peak; $rose(o0.ref_hold) |-> act_cnt_ff >= PEAK_CYCLES && act_cnt_ff <= PEAK_CYCLES + 2;
  endproperty
  a_peak: assert property (p_peak) else $error("peak interval wrong");
  property p_hold; $rose(o0.ref_hold) && !tbl_wr.wr_en |=> o0.ref_code == hold_ff; endproperty
  a_hold: assert property (p_hold) else $error("hold code wrong");
  c_min_on: cover property (o0.drive && on_cnt_ff == 299 && current_trip[0]);
  c_hold: cover property ($rose(o0.ref_hold));
  c_fault: cover property ($fell(o1.fault_pin_oe_n));
endmodule : sphs_ctrl_chk

bind sphs_ctrl sphs_ctrl_chk #(.PEAK_CYCLES(PEAK_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES),
  .SLOW_DIV(SLOW_DIV)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .sol_cmd(sol_cmd),
  .current_trip(current_trip), .drv_fault(drv_fault), .tbl_wr(tbl_wr), .sol_out(sol_out),
  .ready(ready));

// ==== bench/sphs_coil_model.sv ====
// coil and comparator model: trips after a chosen number of drive-high cycles
`timescale 1ns/1ps
module sphs_coil_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // drive and trip threshold
  input wire logic drive,
  input wire logic [31:0] trip_after,
  // comparator result
  output logic current_trip
);
  int cnt_ff;
  // current decays at once when released, so the trip drops one cycle after the drive
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 0;
      current_trip <= 1'b0;
    end
    else if (!drive)
    begin
      cnt_ff <= 0;
      current_trip <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 1;
      current_trip <= (cnt_ff + 1 >= trip_after);
    end
  end
endmodule : sphs_coil_model

// ==== bench/tb_sphs_ctrl.sv ====
// self-checking bench for the solenoid peak/hold controller
`timescale 1ns/1ps
module tb_sphs_ctrl;
  import sphs_pkg::*;
  localparam int PK = 200;
  localparam int HALF = 2 * 64 * 16;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] sol_cmd = 2'h0;
  logic [1:0] drv_fault = 2'h0;
  wire logic [1:0] current_trip;
  sphs_tbl_wr_t tbl_wr = '0;
  sphs_sol_out_t [1:0] sol_out;
  logic ready;
  logic [31:0] seed = 32'h0001_2A25;
  int lim [2] = '{1, 1};
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int on_cnt = 0;
  int rise_q [$];
  int width_q [$];
  always #5 ref_clk = ~ref_clk;
  sphs_ctrl #(.PEAK_CYCLES(PK), .STARTUP_CYCLES(20), .SLOW_DIV(2)) uut (.ref_clk(ref_clk),
    .rst_n(rst_n), .sol_cmd(sol_cmd), .current_trip(current_trip), .drv_fault(drv_fault),
    .tbl_wr(tbl_wr), .sol_out(sol_out), .ready(ready));
  sphs_coil_model u_coil0 (.ref_clk(ref_clk), .rst_n(rst_n), .drive(sol_out[0].drive),
    .trip_after(lim[0]), .current_trip(current_trip[0]));
  sphs_coil_model u_coil1 (.ref_clk(ref_clk), .rst_n(rst_n), .drive(sol_out[1].drive),
    .trip_after(lim[1]), .current_trip(current_trip[1]));
  // ---
  // reference model: rise times and on-widths of the first drive
  // ---
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (sol_out[0].drive)
    begin
      if (on_cnt == 0)
        rise_q.push_back(cyc);
      on_cnt <= on_cnt + 1;
    end
    else if (on_cnt != 0)
    begin
      width_q.push_back(on_cnt);
      on_cnt <= 0;
    end
  end
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // bounded waits: a timeout leaves a value that cannot match
  task automatic wait_width(output int w);
    for (int k = 0; k < 9000 && width_q.size() == 0; k++)
      tick(1);
    w = (width_q.size() != 0) ? width_q.pop_front() : -1;
  endtask : wait_width
  task automatic wait_green(output int t);
    logic g;
    g = sol_out[1].green_led;
    for (t = 0; t < 3000 && sol_out[1].green_led === g; t++)
      tick(1);
  endtask : wait_green
  task automatic hold_check(input logic [7:0] pk, input logic [7:0] hd);
    int k;
    for (k = 0; k < 400 && sol_out[0].ref_hold !== 1'b1; k++)
    begin
      tick(1);
      #1;
    end
    // pulse one edge after the counter ends, selector one edge later
    check(k, PK + 1);
    check(sol_out[0].ref_code, pk);
    tick(1);
    #1;
    check(sol_out[0].ref_code, hd);
  endtask : hold_check
  initial
  begin
    #1_000_000;
    err_count++;
    finish_test();
  end
  initial
  begin
    int w;
    int k;
    logic [7:0] d;
    tick(5);
    rst_n <= 1'b1;
    for (k = 0; k < 100 && ready !== 1'b1; k++)
      tick(1);
    check(ready, 1'b1);
    sol_cmd <= 2'h3;
    hold_check(8'hDA, 8'hC4);
    check(sol_out[1].ref_code, 8'hC3);
    check(sol_out[0].green_led, 1'b1);
    wait_width(w);
    check(w, 300);
    repeat (4)
    begin
      seed = nxt_rand(seed);
      lim[0] = 1 + int'(seed[9:0]);
      wait_width(w);
      check(w, lim[0] >= 300 ? lim[0] + 1 : 300);
      check(rise_q[$] - rise_q[$-1], SPHS_PWM_PERIOD_CYCLES);
    end
    drv_fault <= 2'h2;
    tick(3);
    #1;
    check(sol_out[1].fault_pin_oe_n, 1'b0);
    check(sol_out[1].fault_pin_o, 1'b0);
    check(sol_out[1].red_led, 1'b1);
    check(sol_out[0].red_led, 1'b0);
    wait_green(w);
    wait_green(w);
    check(w, HALF);
    drv_fault <= 2'h0;
    tick(3);
    #1;
    check(sol_out[1].red_led, 1'b0);
    check(sol_out[1].green_led, 1'b1);
    width_q.delete();
    for (k = 0; k < 5000 && sol_out[0].drive !== 1'b1; k++)
      tick(1);
    // a drive that never re-arms runs the loop out and fails here
    check(sol_out[0].drive, 1'b1);
    tick(100);
    sol_cmd <= 2'h2;
    tick(2);
    #1;
    check(sol_out[0].drive, 1'b0);
    check(sol_out[0].driver_on, 1'b0);
    check(sol_out[0].ref_hold, 1'b0);
    check(sol_out[0].green_led, 1'b0);
    seed = nxt_rand(seed);
    d = seed[7:0];
    tick(1);
    tbl_wr <= '{1'b1, 4'h8, d};
    tick(1);
    tbl_wr <= '{1'b1, 4'h9, ~d};
    tick(1);
    tbl_wr <= '0;
    sol_cmd <= 2'h3;
    hold_check(d, ~d);
    finish_test();
  end
endmodule : tb_sphs_ctrl
